// File: abx_exec.v
// Purpose: Executes arithmetic, logic, branch and skip operations
// Assumes: Fetch stage supplies decoded op and operand values
// Notes:   Results commit at the last cycle of each operation
//          Operands need only stand at the take edge
//
// Implementation choices: the address map and the APB slave port.
`timescale 1ns/1ps
`include "abx_regs.vh"
module abx_exec (
   input  wire        CLK,
   input  wire        RST,
   input  wire        PSEL,
   input  wire        PENABLE,
   input  wire        PWRITE,
   input  wire [7:0]  PADDR,
   input  wire [31:0] PWDATA,
   output reg  [31:0] PRDATA,
   output wire        PREADY,
   output wire        PSLVERR,
   input  wire        ISSUE_VALID,
   output wire        ISSUE_READY,
   input  wire [4:0]  OP,
   input  wire        USE_IMM,
   input  wire [7:0]  RD_VAL,
   input  wire [7:0]  RD_HI_VAL,
   input  wire [7:0]  RR_VAL,
   input  wire [7:0]  IMM,
   input  wire [2:0]  BIT_SEL,
   input  wire [7:0]  IO_VAL,
   input  wire [6:0]  BR_OFS,
   input  wire [15:0] Z_PTR,
   input  wire        NEXT_LONG,
   output reg         WB_BYTE,
   output reg  [7:0]  WB_DATA,
   output reg         WB_PAIR,
   output reg         WB_R1R0,
   output reg  [15:0] WB_WORD,
   output reg         PUSH_VALID,
   output reg  [15:0] PUSH_DATA,
   output reg         DONE,
   output wire [15:0] PC,
   output wire [7:0]  FLAGS
);
   // One-hot sequencer states
   localparam ST_IDLE = 2'b01;
   localparam ST_WAIT = 2'b10;

   // Architectural and bookkeeping state
   reg  [1:0]  st_q;
   reg  [1:0]  cnt_q;
   reg  [7:0]  flg_q;
   reg  [15:0] pc_q;
   reg  [31:0] ops_q;
   // Pending commit of a multi-cycle operation
   reg  [7:0]  p_flg_q;
   reg  [15:0] p_pc_q;
   reg  [7:0]  p_byte_q;
   reg  [15:0] p_word_q;
   reg  [4:0]  p_kind_q;

   // Combinational results of the issued operation
   reg  [7:0]  n_flg;
   reg  [15:0] n_pc;
   reg  [7:0]  n_byte;
   reg  [15:0] n_word;
   reg  [4:0]  n_kind;   // byte,pair,r1r0,push,nop
   reg  [1:0]  n_cyc;
   reg  [8:0]  r9;
   reg  [4:0]  h5;
   reg  [16:0] w17;
   reg  [15:0] prod;
   reg         take;
   reg         fsel;

   // Operand selection and shared arithmetic
   wire        fire = ISSUE_VALID && st_q[0];
   wire [7:0]  src = USE_IMM ? IMM : RR_VAL;
   wire        cin = flg_q[`ABX_C];
   wire        sub_c = (OP == `OP_SUBC) || (OP == `OP_CMPC);
   // Branch target counts from the following word
   wire [15:0] pc_nx = pc_q + 16'h0001;
   wire [15:0] br_tgt = pc_nx + {{9{BR_OFS[6]}}, BR_OFS};
   wire [15:0] pair = {RD_HI_VAL, RD_VAL};

   // Sign-extend only the operands the op treats as signed
   wire        sgn_a = (OP == `OP_SMUL) || (OP == `OP_SUMUL) ||
                       (OP == `OP_FMULS) || (OP == `OP_FMULSU);
   wire        sgn_b = (OP == `OP_SMUL) || (OP == `OP_FMULS);
   wire [15:0] mul_a = {{8{sgn_a & RD_VAL[7]}}, RD_VAL};
   wire [15:0] mul_b = {{8{sgn_b & RR_VAL[7]}}, RR_VAL};
   wire        frac = (OP == `OP_FMULU) || (OP == `OP_FMULS) ||
                      (OP == `OP_FMULSU);

   // Commit timing
   wire        last = st_q[1] && (cnt_q == 2'd1);
   wire        commit_now = fire && (n_cyc == `CYC_ONE);

   // APB decode, ahead of the sequencer that writes through it
   wire        apb_map = (PADDR == `ABX_FLAGS_OFS) || (PADDR == `ABX_PC_OFS) ||
                         (PADDR == `ABX_COUNT_OFS) || (PADDR == `ABX_STAT_OFS);
   wire        apb_wr = PSEL && PENABLE && PWRITE && apb_map;

   // Handshake and architectural outputs
   assign ISSUE_READY = st_q[0];
   assign PC = pc_q;
   assign FLAGS = flg_q;

   // ==========================================
   // Operation evaluation
   // Defaults keep every output driven on every path
   always @* begin
      n_flg  = flg_q;      // Untouched flags keep value
      n_pc   = pc_nx;
      n_byte = 8'h00;
      n_word = 16'h0000;
      n_kind = 5'b10000;
      n_cyc  = `CYC_ONE;
      r9     = 9'h000;
      h5     = 5'h00;
      w17    = 17'h00000;
      prod   = mul_a * mul_b;
      take   = 1'b0;
      fsel   = flg_q[BIT_SEL];
      case (OP)
         `OP_ADD, `OP_ADC: begin
            // Carry-in only for the carry form
            r9 = {1'b0, RD_VAL} + {1'b0, RR_VAL} +
                 {8'h00, (OP == `OP_ADC) & cin};
            h5 = {1'b0, RD_VAL[3:0]} + {1'b0, RR_VAL[3:0]} +
                 {4'h0, (OP == `OP_ADC) & cin};
            n_byte = r9[7:0];
            n_kind = 5'b00001;
            n_flg[`ABX_C] = r9[8];
            n_flg[`ABX_H] = h5[4];
            n_flg[`ABX_Z] = (r9[7:0] == 8'h00);
            n_flg[`ABX_N] = r9[7];
            n_flg[`ABX_V] = (RD_VAL[7] == RR_VAL[7]) &&
                            (r9[7] != RD_VAL[7]);
         end
         `OP_SUB, `OP_SUBC, `OP_CP, `OP_CMPC: begin
            r9 = {1'b0, RD_VAL} - {1'b0, src} -
                 {8'h00, sub_c & cin};
            h5 = {1'b0, RD_VAL[3:0]} - {1'b0, src[3:0]} -
                 {4'h0, sub_c & cin};
            n_byte = r9[7:0];
            // Compares leave the register file alone
            n_kind = ((OP == `OP_CP) || (OP == `OP_CMPC)) ?
                     5'b10000 : 5'b00001;
            n_flg[`ABX_C] = r9[8];
            n_flg[`ABX_H] = h5[4];
            // Carry forms chain zero across bytes
            n_flg[`ABX_Z] = (r9[7:0] == 8'h00) &&
                            (!sub_c || flg_q[`ABX_Z]);
            n_flg[`ABX_N] = r9[7];
            n_flg[`ABX_V] = (RD_VAL[7] != src[7]) &&
                            (r9[7] != RD_VAL[7]);
         end
         `OP_AND, `OP_OR, `OP_XOR, `OP_SETB, `OP_CLRB, `OP_TEST: begin
            case (OP)
               `OP_AND:  n_byte = RD_VAL & src;
               `OP_OR:   n_byte = RD_VAL | src;
               `OP_XOR:  n_byte = RD_VAL ^ src;
               `OP_SETB: n_byte = RD_VAL | IMM;
               `OP_CLRB: n_byte = RD_VAL & (8'hFF - IMM);
               default:  n_byte = RD_VAL & RD_VAL;
            endcase
            n_kind = 5'b00001;
            n_flg[`ABX_Z] = (n_byte == 8'h00);
            n_flg[`ABX_N] = n_byte[7];
            // Overflow always cleared by logic ops
            n_flg[`ABX_V] = 1'b0;
         end
         `OP_WADD, `OP_WSUB: begin
            // Constant is six bits; S is N xor V
            if (OP == `OP_WADD) begin
               w17 = {1'b0, pair} + {11'h000, IMM[5:0]};
               n_flg[`ABX_C] = w17[16];
               n_flg[`ABX_V] = !RD_HI_VAL[7] && w17[15];
            end else begin
               w17 = {1'b0, pair} - {11'h000, IMM[5:0]};
               n_flg[`ABX_C] = w17[16];
               n_flg[`ABX_V] = RD_HI_VAL[7] && !w17[15];
            end
            n_word = w17[15:0];
            n_kind = 5'b00010;
            n_cyc  = `CYC_WORD;
            n_flg[`ABX_Z] = (w17[15:0] == 16'h0000);
            n_flg[`ABX_N] = w17[15];
            n_flg[`ABX_S] = w17[15] ^ n_flg[`ABX_V];
         end
         `OP_MULU, `OP_SMUL, `OP_SUMUL,
         `OP_FMULU, `OP_FMULS, `OP_FMULSU: begin
            // Carry is the product top bit before any shift
            n_word = frac ? {prod[14:0], 1'b0} : prod;
            n_kind = 5'b00100;
            n_cyc  = `CYC_MUL;
            n_flg[`ABX_C] = prod[15];
            n_flg[`ABX_Z] = (n_word == 16'h0000);
         end
         `OP_PJMP: begin
            // Only PC moves; flags stay
            n_pc  = Z_PTR;
            n_cyc = `CYC_JMP;
         end
         `OP_PCALL: begin
            // Return address is the next word
            n_pc   = Z_PTR;
            n_word = pc_nx;
            n_kind = 5'b01000;
            n_cyc  = `CYC_CALL;
         end
         `OP_CMPSE, `OP_SRBC, `OP_SRBS, `OP_SIOC, `OP_SIOS: begin
            // Skip length follows the width of the next instruction
            case (OP)
               `OP_CMPSE: take = (RD_VAL == RR_VAL);
               `OP_SRBC: take = !RR_VAL[BIT_SEL];
               `OP_SRBS: take = RR_VAL[BIT_SEL];
               `OP_SIOC: take = !IO_VAL[BIT_SEL];
               default:  take = IO_VAL[BIT_SEL];
            endcase
            if (take) begin
               n_pc  = pc_q + (NEXT_LONG ? 16'h0003 : 16'h0002);
               n_cyc = NEXT_LONG ? `CYC_SKIP2 : `CYC_SKIP1;
            end
         end
         `OP_BRS, `OP_BRC, `OP_BRSGE, `OP_BRLT: begin
            // Named branches map onto flag select and sense
            case (OP)
               `OP_BRS:  take = fsel;
               `OP_BRC:  take = !fsel;
               `OP_BRSGE: take = !(flg_q[`ABX_N] ^ flg_q[`ABX_V]);
               default:  take = flg_q[`ABX_N] ^ flg_q[`ABX_V];
            endcase
            if (take) begin
               n_pc  = br_tgt;
               n_cyc = `CYC_BRT;
            end
         end
         default: begin
            // Unknown codes retire as one-cycle no-ops
            n_kind = 5'b10000;
         end
      endcase
   end

   // ==========================================
   // Sequencer and commit
   // Commit wins over a software write in the same cycle
   always @(posedge CLK) begin
      if (RST) begin
         // Idle, all state zero except p_kind_q at no-op, no pulse pending
         st_q      <= ST_IDLE;
         cnt_q     <= 2'd0;
         flg_q     <= `ABX_FLAGS_RST;
         pc_q      <= `ABX_PC_RST;
         ops_q     <= 32'h00000000;
         p_flg_q   <= 8'h00;
         p_pc_q    <= 16'h0000;
         p_byte_q  <= 8'h00;
         p_word_q  <= 16'h0000;
         p_kind_q  <= 5'b10000;
         WB_BYTE   <= 1'b0;
         WB_DATA   <= 8'h00;
         WB_PAIR   <= 1'b0;
         WB_R1R0   <= 1'b0;
         WB_WORD   <= 16'h0000;
         PUSH_VALID <= 1'b0;
         PUSH_DATA <= 16'h0000;
         DONE      <= 1'b0;
      end else begin
         WB_BYTE    <= 1'b0;
         WB_PAIR    <= 1'b0;
         WB_R1R0    <= 1'b0;
         PUSH_VALID <= 1'b0;
         DONE       <= 1'b0;
         // Software access; PC only while idle so no op is lost
         if (apb_wr && (PADDR == `ABX_FLAGS_OFS))
            flg_q <= PWDATA[7:0];
         if (apb_wr && (PADDR == `ABX_PC_OFS) && st_q[0])
            pc_q <= PWDATA[15:0];
         case (st_q)
            ST_IDLE: begin
               // Single-cycle ops retire at the take edge
               if (commit_now) begin
                  flg_q      <= n_flg;
                  pc_q       <= n_pc;
                  WB_BYTE    <= n_kind[0];
                  WB_DATA    <= n_byte;
                  ops_q      <= ops_q + 32'h00000001;
                  DONE       <= 1'b1;
               end else if (fire) begin
                  // Hold results, commit on final cycle
                  st_q     <= ST_WAIT;
                  cnt_q    <= n_cyc - 2'd1;
                  p_flg_q  <= n_flg;
                  p_pc_q   <= n_pc;
                  p_byte_q <= n_byte;
                  p_word_q <= n_word;
                  p_kind_q <= n_kind;
               end
            end
            ST_WAIT: begin
               // Count down to the commit edge
               cnt_q <= cnt_q - 2'd1;
               if (last) begin
                  st_q       <= ST_IDLE;
                  flg_q      <= p_flg_q;
                  pc_q       <= p_pc_q;
                  WB_BYTE    <= p_kind_q[0];
                  WB_DATA    <= p_byte_q;
                  WB_PAIR    <= p_kind_q[1];
                  WB_R1R0    <= p_kind_q[2];
                  WB_WORD    <= p_word_q;
                  PUSH_VALID <= p_kind_q[3];
                  PUSH_DATA  <= p_word_q;
                  ops_q      <= ops_q + 32'h00000001;
                  DONE       <= 1'b1;
               end
            end
            default: begin
               st_q <= ST_IDLE;
            end
         endcase
      end
   end

   // ==========================================
   // APB slave, zero wait states
   assign PREADY  = 1'b1;
   assign PSLVERR = PSEL && PENABLE && !apb_map;

   // Read data captured in setup phase, stable through access
   always @(posedge CLK) begin
      if (RST) begin
         PRDATA <= 32'h00000000;
      end else if (PSEL && !PENABLE) begin
         case (PADDR)
            `ABX_FLAGS_OFS: PRDATA <= {24'h000000, flg_q};
            `ABX_PC_OFS:    PRDATA <= {16'h0000, pc_q};
            `ABX_COUNT_OFS: PRDATA <= ops_q;
            `ABX_STAT_OFS:  PRDATA <= {28'h0000000, cnt_q, st_q[1], st_q[0]};
            default:        PRDATA <= 32'h00000000;
         endcase
      end
   end
endmodule

// File: abx_exec_bench.sv
// Purpose: Self-checking bench for the execution unit
// Assumes: Flags are preset over APB before operations
// Notes:   Cycle count is edges from take edge to done
`timescale 1ns/1ps
`include "abx_regs.vh"
module abx_exec_bench;
   logic        CLK = 0, RST = 1, PSEL = 0, PENABLE = 0, PWRITE = 0, ISSUE_VALID = 0, USE_IMM = 0, NEXT_LONG = 0;
   logic [7:0]  PADDR = 0, RD_VAL = 0, RD_HI_VAL = 0, RR_VAL = 0, IMM = 0, IO_VAL = 0, er, ef, v;
   logic [31:0] PWDATA = 0, rd;
   logic [4:0]  OP = 0;
   logic [2:0]  BIT_SEL = 0;
   logic [6:0]  BR_OFS = 0;
   logic [15:0] Z_PTR = 0, pc_m = 0;
   logic        err, cmp;
   wire  [31:0] PRDATA;
   wire         PREADY, PSLVERR, ISSUE_READY, WB_BYTE, WB_PAIR, WB_R1R0, PUSH_VALID, DONE;
   wire  [7:0]  WB_DATA, FLAGS;
   wire  [15:0] WB_WORD, PUSH_DATA, PC;
   int          miscompares = 0, n_checks = 0, cyc, ec, k;
   // Byte vectors: op, imm flag, a, b, preset flags
   logic [31:0] tv [17] = '{{`OP_ADD,3'd0,24'h0F0100}, {`OP_ADD,3'd0,24'h8080D0}, {`OP_ADC,3'd0,24'hFF0001},
      {`OP_SUB,3'd0,24'h100100}, {`OP_SUB,3'd1,24'h800104}, {`OP_SUBC,3'd0,24'h050503}, {`OP_SUBC,3'd1,24'h050401},
      {`OP_SUBC,3'd0,24'h050403}, {`OP_AND,3'd0,24'hF03C08}, {`OP_OR,3'd1,24'h00002D}, {`OP_XOR,3'd0,24'hFF8004},
      {`OP_SETB,3'd1,24'h018000}, {`OP_CLRB,3'd1,24'hFF0F00}, {`OP_TEST,3'd0,24'h800008}, {`OP_CP,3'd0,24'h010200},
      {`OP_CMPC,3'd0,24'h020202}, {`OP_CP,3'd1,24'h7FFF00}};
   logic [15:0] mv [6] = '{16'hFFFF, 16'h8080, 16'hFF02, 16'h8080, 16'hC040, 16'h0055};
   abx_exec dut_u (.CLK(CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
      .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .ISSUE_VALID(ISSUE_VALID),
      .ISSUE_READY(ISSUE_READY), .OP(OP), .USE_IMM(USE_IMM), .RD_VAL(RD_VAL), .RD_HI_VAL(RD_HI_VAL),
      .RR_VAL(RR_VAL), .IMM(IMM), .BIT_SEL(BIT_SEL), .IO_VAL(IO_VAL), .BR_OFS(BR_OFS), .Z_PTR(Z_PTR),
      .NEXT_LONG(NEXT_LONG), .WB_BYTE(WB_BYTE), .WB_DATA(WB_DATA), .WB_PAIR(WB_PAIR), .WB_R1R0(WB_R1R0),
      .WB_WORD(WB_WORD), .PUSH_VALID(PUSH_VALID), .PUSH_DATA(PUSH_DATA), .DONE(DONE), .PC(PC), .FLAGS(FLAGS));
   always #2.5 CLK = ~CLK;
   // ==========================================
   // Shared tasks
   task chk(input string n, input logic [31:0] s, input logic [31:0] x);
      n_checks++;
      if (s !== x) begin
         miscompares++;
         $display("BAD %s expected %h seen %h", n, x, s);
      end
   endtask
   task conclude;
      if (miscompares == 0 && n_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   // APB transfer; no wait state assumed, pready still waited on
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge CLK);
      PSEL <= 1; PENABLE <= 0; PWRITE <= w; PADDR <= a; PWDATA <= d;
      @(posedge CLK);
      PENABLE <= 1;
      do @(posedge CLK); while (PREADY !== 1'b1);
      rd = PRDATA; err = PSLVERR;
      PSEL <= 0; PENABLE <= 0;
   endtask
   // Wrong operand source shows up because the unused one is inverted
   task go(input [4:0] op, input [7:0] a, b, input u, input [7:0] hi, input [15:0] x, input int c);
      @(posedge CLK);
      OP <= op; RD_VAL <= a; RR_VAL <= u ? ~b : b; IMM <= u ? b : ~b; USE_IMM <= u; RD_HI_VAL <= hi;
      IO_VAL <= b; Z_PTR <= x; BR_OFS <= x[6:0]; BIT_SEL <= x[10:8]; NEXT_LONG <= x[11]; ISSUE_VALID <= 1;
      @(posedge CLK);
      ISSUE_VALID <= 0; cyc = 1;
      #1 while (DONE !== 1'b1 && cyc < 9) begin @(posedge CLK); #1 cyc++; end
      chk("cycles", cyc, c);
   endtask
   function automatic logic [15:0] ref8(input [4:0] o, input [7:0] a, b, f);
      logic [8:0] r; logic [7:0] g; logic s;
      g = f; s = (o == `OP_SUB || o == `OP_SUBC || o == `OP_CP || o == `OP_CMPC);
      if (s) r = {1'b0, a} - b - ((o == `OP_SUBC || o == `OP_CMPC) & f[0]);
      else if (o <= `OP_ADC) r = {1'b0, a} + b + ((o == `OP_ADC) & f[0]);
      else r = o == `OP_AND ? a & b : (o == `OP_OR || o == `OP_SETB) ? a | b : o == `OP_XOR ? a ^ b : o == `OP_CLRB ? a & ~b : a;
      if (s || o <= `OP_ADC) begin
         g[0] = r[8];
         g[5] = s ? (~a[3] & b[3]) | (b[3] & r[3]) | (r[3] & ~a[3]) : (a[3] & b[3]) | (b[3] & ~r[3]) | (~r[3] & a[3]);
         g[3] = s ? (a[7] & ~b[7] & ~r[7]) | (~a[7] & b[7] & r[7]) : (a[7] & b[7] & ~r[7]) | (~a[7] & ~b[7] & r[7]);
      end else g[3] = 0;
      g[2] = r[7];
      g[1] = (r[7:0] == 0) & ((o != `OP_SUBC && o != `OP_CMPC) | f[1]);
      return {r[7:0], g};
   endfunction
   task automatic word(input [4:0] op, input [7:0] hi, lo, k);
      logic [16:0] r; logic vv;
      r = op == `OP_WADD ? {1'b0, hi, lo} + k : {1'b0, hi, lo} - k;
      vv = op == `OP_WADD ? ~hi[7] & r[15] : hi[7] & ~r[15];
      apb(1, `ABX_FLAGS_OFS, 32'h80);
      go(op, lo, k, 1, hi, 0, 2);
      chk("word", {WB_PAIR, WB_WORD}, {1'b1, r[15:0]});
      chk("wflags", FLAGS, {3'b100, r[15] ^ vv, vv, r[15], r[15:0] == 0, r[16]});
      pc_m++;
   endtask
   task automatic mul(input [4:0] op, input [7:0] a, b);
      logic [15:0] sa, sb, p, q;
      sa = (op == `OP_MULU || op == `OP_FMULU) ? {8'h00, a} : {{8{a[7]}}, a};
      sb = (op == `OP_SMUL || op == `OP_FMULS) ? {{8{b[7]}}, b} : {8'h00, b};
      p = sa * sb;
      q = op >= `OP_FMULU ? {p[14:0], 1'b0} : p;
      apb(1, `ABX_FLAGS_OFS, 32'hFC);
      go(op, a, b, 0, 0, 0, 2);
      chk("product", {WB_R1R0, WB_WORD}, {1'b1, q});
      chk("mflags", FLAGS, {6'h3F, q == 0, p[15]});
      pc_m++;
   endtask
   task automatic br(input [4:0] op, input [2:0] s, input t);
      logic [6:0] o;
      o = s[0] ? 7'h7D : 7'h05;
      go(op, 0, 0, 0, 0, {5'b0, s, 1'b0, o}, t ? 2 : 1);
      pc_m = t ? pc_m + 1 + {{9{o[6]}}, o} : pc_m + 1;
      chk("br_pc", PC, pc_m);
   endtask
   // ==========================================
   // Watchdog and main sequence
   initial begin
      #40000;
      miscompares++;
      conclude;
   end
   initial begin
      repeat (8) @(posedge CLK);
      RST <= 0;
      apb(0, `ABX_FLAGS_OFS, 0);
      chk("flags_rst", {rd[7:0], PC, ISSUE_READY}, {8'h00, 16'h0000, 1'b1});
      for (int i = 0; i < 17; i++) begin
         {er, ef} = ref8(tv[i][31:27], tv[i][23:16], tv[i][15:8], tv[i][7:0]);
         cmp = tv[i][31:27] == `OP_CP || tv[i][31:27] == `OP_CMPC;
         apb(1, `ABX_FLAGS_OFS, {24'h0, tv[i][7:0]});
         go(tv[i][31:27], tv[i][23:16], tv[i][15:8], tv[i][24], 0, 0, 1);
         chk("flags", FLAGS, ef);
         chk("wb_byte", WB_BYTE, !cmp);
         if (!cmp) chk("result", WB_DATA, er);
         pc_m++;
      end
      word(`OP_WADD, 8'h7F, 8'hFF, 8'h01);
      word(`OP_WSUB, 8'h00, 8'h00, 8'h01);
      word(`OP_WADD, 8'hFF, 8'hC1, 8'h3F);
      for (int i = 0; i < 6; i++) mul(`OP_MULU + i, mv[i][15:8], mv[i][7:0]);
      apb(1, `ABX_FLAGS_OFS, 32'h5A);
      go(`OP_PJMP, 0, 0, 0, 0, 16'h1234, 2);
      chk("jump", {PC, FLAGS}, {16'h1234, 8'h5A});
      go(`OP_PCALL, 0, 0, 0, 0, 16'h0200, 3);
      chk("call", {PUSH_VALID, PUSH_DATA, PC, FLAGS}, {1'b1, 16'h1235, 16'h0200, 8'h5A});
      pc_m = 16'h0200;
      for (k = 0; k < 19; k++) begin
         v = k[0] ? 8'h01 << k[2:0] : ~(8'h01 << k[2:0]);
         ec = k > 15 ? (k == 18 ? 1 : 2 + k[0]) : (k[0] == k[2] ? 2 + k[1] : 1);
         if (k > 15) go(`OP_CMPSE, 8'h33, k == 18 ? 8'h34 : 8'h33, 0, 0, {4'b0, k[0], 11'b0}, ec);
         else go(`OP_SRBC + k[3:2], v, v, 0, 0, {4'b0, k[1], k[2:0], 8'h00}, ec);
         pc_m = pc_m + ec;
         chk("skip", {PC, FLAGS}, {pc_m, 8'h5A});
      end
      apb(1, `ABX_FLAGS_OFS, 32'hA5);
      for (k = 0; k < 16; k++) br(k[3] ? `OP_BRC : `OP_BRS, k[2:0], 8'hA5 >> k[2:0] & 1 ^ k[3]);
      for (k = 0; k < 8; k++) begin
         apb(1, `ABX_FLAGS_OFS, {28'h0, k[1:0], 2'b00});
         br(k[2] ? `OP_BRLT : `OP_BRSGE, 3'd0, (k[1] ^ k[0]) == k[2]);
      end
      apb(0, `ABX_PC_OFS, 0);
      chk("pc_reg", rd[15:0], pc_m);
      apb(1, `ABX_PC_OFS, 32'h00000ABC);
      apb(0, `ABX_PC_OFS, 0);
      chk("pc_wr", rd[15:0], 16'h0ABC);
      // 71 operations issued above, each retired once
      apb(0, `ABX_COUNT_OFS, 0);
      chk("op_count", rd, 32'h00000047);
      apb(0, `ABX_STAT_OFS, 0);
      chk("status", rd, 32'h00000001);
      apb(0, 8'h10, 0);
      chk("unmapped", {err, rd}, {1'b1, 32'h0});
      conclude;
   end
endmodule

// File: abx_exec_props.sv
// Purpose: Timing and flag checks on the execution unit ports
// Assumes: Operations are issued only while the unit is idle
// Notes:   Counts are taken from the take edge
`timescale 1ns/1ps
`include "abx_regs.vh"
module abx_exec_props (
   input wire logic        CLK,
   input wire logic        RST,
   input wire logic        ISSUE_VALID,
   input wire logic        ISSUE_READY,
   input wire logic [4:0]  OP,
   input wire logic [2:0]  BIT_SEL,
   input wire logic [6:0]  BR_OFS,
   input wire logic [15:0] Z_PTR,
   input wire logic        WB_BYTE,
   input wire logic        WB_PAIR,
   input wire logic        WB_R1R0,
   input wire logic [15:0] WB_WORD,
   input wire logic        PUSH_VALID,
   input wire logic [15:0] PUSH_DATA,
   input wire logic        DONE,
   input wire logic [15:0] PC,
   input wire logic [7:0]  FLAGS
);
   // ==========================================
   // Helpers
   wire        take  = ISSUE_VALID && ISSUE_READY;
   wire [15:0] ofs_x = {{9{BR_OFS[6]}}, BR_OFS};
   default clocking cb @(posedge CLK); endclocking
   default disable iff (RST);
   // ==========================================
   // Properties
   a_alu_one_cyc: assert property (take && (OP <= `OP_TEST || OP == `OP_CP || OP == `OP_CMPC) |=> DONE)
      else $error("alu op not done in one cycle");
   a_word_two_cyc: assert property (take && (OP == `OP_WADD || OP == `OP_WSUB) |=> !DONE && !ISSUE_READY ##1 DONE && WB_PAIR)
      else $error("word op timing wrong");
   a_mul_zero_flag: assert property (take && OP >= `OP_MULU && OP <= `OP_FMULSU
      |=> !ISSUE_READY ##1 DONE && WB_R1R0 && (FLAGS[1] == (WB_WORD == 16'h0000)))
      else $error("multiply timing or zero flag wrong");
   a_jump_from_z: assert property (take && OP == `OP_PJMP |-> ##2 DONE && PC == $past(Z_PTR, 2) && FLAGS == $past(FLAGS, 2))
      else $error("pointer jump wrong");
   a_call_push_ret: assert property (take && OP == `OP_PCALL |=> !DONE [*2] ##1 DONE && PUSH_VALID
      && PC == $past(Z_PTR, 3) && PUSH_DATA == $past(PC, 3) + 16'h0001)
      else $error("pointer call wrong");
   a_cmp_no_store: assert property (take && (OP == `OP_CP || OP == `OP_CMPC) |=> DONE && !WB_BYTE)
      else $error("compare wrote a result");
   a_logic_flags_kept: assert property (take && OP >= `OP_AND && OP <= `OP_TEST
      |=> !FLAGS[3] && (FLAGS & 8'hF1) == ($past(FLAGS) & 8'hF1))
      else $error("logic op flags wrong");
   a_branch_not_taken: assert property (take && OP == `OP_BRS && !FLAGS[BIT_SEL] |=> DONE && PC == $past(PC) + 16'h0001)
      else $error("untaken branch wrong");
   a_branch_taken_pc: assert property (take && OP == `OP_BRC && !FLAGS[BIT_SEL]
      |=> !DONE ##1 DONE && PC == $past(PC, 2) + 16'h0001 + $past(ofs_x, 2))
      else $error("taken branch wrong");
endmodule
bind abx_exec abx_exec_props chk_u (.CLK(CLK), .RST(RST), .ISSUE_VALID(ISSUE_VALID), .ISSUE_READY(ISSUE_READY),
   .OP(OP), .BIT_SEL(BIT_SEL), .BR_OFS(BR_OFS), .Z_PTR(Z_PTR), .WB_BYTE(WB_BYTE), .WB_PAIR(WB_PAIR),
   .WB_R1R0(WB_R1R0), .WB_WORD(WB_WORD), .PUSH_VALID(PUSH_VALID), .PUSH_DATA(PUSH_DATA), .DONE(DONE),
   .PC(PC), .FLAGS(FLAGS));

// File: abx_regs.vh
// Purpose: Constants for the arithmetic and branch execution unit
// Assumes: Included by abx_exec.v and by the bench and property modules
// Notes:   Offsets are APB byte addresses
//
// Functional notes
// - Add and add-carry write sum, five flags
// - Word add/sub immediate, ZCNVS, two cycles
// - Subtract register or constant, ZCNVH, one cycle
// - Subtract with carry also subtracts carry
// - AND, OR, XOR write result, ZNV only
// - Set bits ORs mask, clear bits ANDs inverse
// - Test ANDs register with itself, ZNV
// - Multiplies write R1:R0, Z and C, two cycles
// - Fractional multiplies shift product left once
// - Pointer jump loads PC from Z, two cycles
// - Pointer call pushes return, loads Z, three
// - Compare-skip-equal skips next, 1/2/3 cycles
// - Register bit skip on clear or set
// - I/O bit skip on requested level
// - Compares update five flags, store nothing
// - Flag branch adds offset plus one if true
// - Signed branches test N xor V
// - Same-or-higher and lower test carry
// - Interrupt branches test global enable flag
// - Single-flag branches test H,T,V,N,Z,C
`ifndef ABX_REGS_VH
`define ABX_REGS_VH
// ==========================================
// Register map
`define ABX_FLAGS_OFS  8'h00
`define ABX_PC_OFS     8'h04
`define ABX_COUNT_OFS  8'h08
`define ABX_STAT_OFS   8'h0C
`define ABX_FLAGS_RST  8'h00
`define ABX_PC_RST     16'h0000
// ==========================================
// Flag positions
`define ABX_C 0
`define ABX_Z 1
`define ABX_N 2
`define ABX_V 3
`define ABX_S 4
`define ABX_H 5
`define ABX_T 6
`define ABX_I 7
// ==========================================
// Operation codes
`define OP_ADD    5'h00
`define OP_ADC    5'h01
`define OP_SUB    5'h02
`define OP_SUBC   5'h03
`define OP_AND    5'h04
`define OP_OR     5'h05
`define OP_XOR    5'h06
`define OP_SETB   5'h07
`define OP_CLRB   5'h08
`define OP_TEST   5'h09
`define OP_WADD   5'h0A
`define OP_WSUB   5'h0B
`define OP_MULU   5'h0C
`define OP_SMUL   5'h0D
`define OP_SUMUL  5'h0E
`define OP_FMULU  5'h0F
`define OP_FMULS  5'h10
`define OP_FMULSU 5'h11
`define OP_PJMP   5'h12
`define OP_PCALL  5'h13
`define OP_CMPSE  5'h14
`define OP_CP     5'h15
`define OP_CMPC   5'h16
`define OP_SRBC   5'h17
`define OP_SRBS   5'h18
`define OP_SIOC   5'h19
`define OP_SIOS   5'h1A
`define OP_BRS    5'h1B
`define OP_BRC    5'h1C
`define OP_BRSGE  5'h1D
`define OP_BRLT   5'h1E
// ==========================================
// Cycle counts
`define CYC_ONE   2'd1
`define CYC_WORD  2'd2
`define CYC_MUL   2'd2
`define CYC_JMP   2'd2
`define CYC_CALL  2'd3
`define CYC_BRT   2'd2
`define CYC_SKIP1 2'd2
`define CYC_SKIP2 2'd3
`endif
